/* rtc_consts.svh */
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ---------------------------------------------------------------------------
// clock source selection
// ---------------------------------------------------------------------------
`define RTC_SRC_AUX        1'b0
`define RTC_SRC_MAIN       1'b1

// ---------------------------------------------------------------------------
// fixed dividers in front of the timer chain
// ---------------------------------------------------------------------------
`define RTC_MAIN_DIV_W     5
`define RTC_MAIN_DIV_LAST  5'h1f
`define RTC_PRE_W          3
`define RTC_PRE_LAST       3'h7

// ---------------------------------------------------------------------------
// stage indices in request vectors
// ---------------------------------------------------------------------------
`define RTC_NSTAGE         5
`define RTC_IDX_PRE_TMR    0
`define RTC_IDX_SUB0       1
`define RTC_IDX_SUB1       2
`define RTC_IDX_SUB2       3
`define RTC_IDX_SUB3       4

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define RTC_MAIN_DIV_RST   5'h00
`define RTC_PRE_RST        3'h0
`define RTC_REQ_RST        5'h00

`endif

/* rtc_pkg.sv */
`include "rtc_consts.svh"

package rtc_pkg;

	// ---------------------------------------------------------------------------
	// state of the chain front end and request outputs
	// ---------------------------------------------------------------------------
	typedef struct packed {
		logic [`RTC_MAIN_DIV_W-1:0] main_div;
		logic [`RTC_PRE_W-1:0]      pre;
		logic [`RTC_NSTAGE-1:0]     req;
		logic                       node;
		logic                       wake;
	} rtc_state_t;

endpackage

/* rtc_stage.sv */
`timescale 1ns/10ps

module rtc_stage #(
	parameter int W = 16
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         tick,
	input  wire logic [W-1:0] reload,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	output logic      [W-1:0] count,
	output logic              ovf
);

	typedef struct packed {
		logic [W-1:0] count;
	} rtc_stage_state_t;

	rtc_stage_state_t s_q;
	rtc_stage_state_t s_d;

	// ---------------------------------------------------------------------------
	// up-counter with reload on overflow; a write overrides a tick
	// ---------------------------------------------------------------------------
	assign ovf   = tick && !wr_en && (s_q.count == {W{1'b1}});
	assign count = s_q.count;

	// next count value
	always_comb begin
		s_d = s_q;
		if (wr_en) begin
			s_d.count = wr_data;
		end else if (ovf) begin
			s_d.count = reload;
		end else if (tick) begin
			s_d.count = s_q.count + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// rst_n is power-on only; system resets do not reach it
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

/* rtc_divider_chain.sv */
// Operation
// - timebase is aux oscillator ticks or main oscillator ticks divided by 32.
// - timebase does not depend on the system clock generation mode.
// - optional 8:1 prescaler first, enabled or bypassed by software.
// - reloadable 16-bit prescaler timer counts the prescaled timebase.
// - prescaler timer feeds four chained reloadable sub-timers: 10, 6, 6, 10 bits.
// - the 32-bit block is read and written as high and low halves.
// - all timers count up and each can raise its own request.
// - all stage requests merge into one node request.
// - timer state is untouched by system reset, only power-on clears it.
// - in sleep or power-down the chain optionally keeps running.
// - selected stage overflows give periodic wake-up pulses during sleep.
`timescale 1ns/10ps
`include "rtc_consts.svh"

module rtc_divider_chain
	import rtc_pkg::*;
#(
	parameter int PRE_TMR_W = 16,
	parameter int SUB0_W    = 10,
	parameter int SUB1_W    = 6,
	parameter int SUB2_W    = 6,
	parameter int SUB3_W    = 10
) (
	input  wire logic                         core_clk,
	input  wire logic                         rst_n,
	input  wire logic                         aux_osc_tick,
	input  wire logic                         main_osc_tick,
	input  wire logic                         clk_src_sel,
	input  wire logic                         prescale_en,
	input  wire logic                         low_power,
	input  wire logic                         run_in_sleep,
	input  wire logic [PRE_TMR_W-1:0]         prescaler_timer_reload,
	input  wire logic                         prescaler_timer_wr,
	input  wire logic [PRE_TMR_W-1:0]         prescaler_timer_wr_data,
	input  wire logic [SUB0_W-1:0]            sub0_reload,
	input  wire logic [SUB1_W-1:0]            sub1_reload,
	input  wire logic [SUB2_W-1:0]            sub2_reload,
	input  wire logic [SUB3_W-1:0]            sub3_reload,
	input  wire logic                         rtc_count_high_wr,
	input  wire logic                         rtc_count_low_wr,
	input  wire logic [SUB3_W+SUB2_W-1:0]     rtc_count_high_wr_data,
	input  wire logic [SUB1_W+SUB0_W-1:0]     rtc_count_low_wr_data,
	input  wire logic [`RTC_NSTAGE-1:0]       req_en,
	input  wire logic [`RTC_NSTAGE-1:0]       wake_en,
	output logic      [PRE_TMR_W-1:0]         prescaler_timer,
	output logic      [SUB3_W+SUB2_W-1:0]     rtc_count_high,
	output logic      [SUB1_W+SUB0_W-1:0]     rtc_count_low,
	output logic      [`RTC_NSTAGE-1:0]       stage_req,
	output logic                              node_req,
	output logic                              wakeup
);

	// ---------------------------------------------------------------------------
	// state and chain wiring
	// ---------------------------------------------------------------------------
	rtc_state_t             s_q;
	rtc_state_t             s_d;
	logic                   run;
	logic                   main_div_tick;
	logic                   src_tick;
	logic                   rtc_tick;
	logic [`RTC_NSTAGE-1:0] ovf;
	logic [SUB0_W-1:0]      sub0_count;
	logic [SUB1_W-1:0]      sub1_count;
	logic [SUB2_W-1:0]      sub2_count;
	logic [SUB3_W-1:0]      sub3_count;

	// wrap test shared by both fixed dividers
	function automatic logic at_last(input logic [7:0] value, input logic [7:0] last);
		at_last = (value == last);
	endfunction

	// ---------------------------------------------------------------------------
	// timebase selection and prescaler
	// ---------------------------------------------------------------------------
	// the chain stops only in low-power mode without the keep-running option
	assign run = !low_power || run_in_sleep;

	// ticks come straight from the oscillators, never from the system clock tree
	assign main_div_tick = main_osc_tick &&
		at_last({3'h0, s_q.main_div}, {3'h0, `RTC_MAIN_DIV_LAST});
	assign src_tick = run && ((clk_src_sel == `RTC_SRC_MAIN) ? main_div_tick
		: aux_osc_tick);

	// 8:1 prescaler or bypass
	assign rtc_tick = prescale_en ?
		(src_tick && at_last({5'h00, s_q.pre}, {5'h00, `RTC_PRE_LAST})) : src_tick;

	// ---------------------------------------------------------------------------
	// timer chain: each overflow is the next stage's tick
	// ---------------------------------------------------------------------------
	rtc_stage #(
		.W (PRE_TMR_W)
	) u_pre_tmr (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (rtc_tick),
		.reload   (prescaler_timer_reload),
		.wr_en    (prescaler_timer_wr),
		.wr_data  (prescaler_timer_wr_data),
		.count    (prescaler_timer),
		.ovf      (ovf[`RTC_IDX_PRE_TMR])
	);

	rtc_stage #(
		.W (SUB0_W)
	) u_sub0 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (ovf[`RTC_IDX_PRE_TMR]),
		.reload   (sub0_reload),
		.wr_en    (rtc_count_low_wr),
		.wr_data  (rtc_count_low_wr_data[SUB0_W-1:0]),
		.count    (sub0_count),
		.ovf      (ovf[`RTC_IDX_SUB0])
	);

	rtc_stage #(
		.W (SUB1_W)
	) u_sub1 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (ovf[`RTC_IDX_SUB0]),
		.reload   (sub1_reload),
		.wr_en    (rtc_count_low_wr),
		.wr_data  (rtc_count_low_wr_data[SUB1_W+SUB0_W-1:SUB0_W]),
		.count    (sub1_count),
		.ovf      (ovf[`RTC_IDX_SUB1])
	);

	rtc_stage #(
		.W (SUB2_W)
	) u_sub2 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (ovf[`RTC_IDX_SUB1]),
		.reload   (sub2_reload),
		.wr_en    (rtc_count_high_wr),
		.wr_data  (rtc_count_high_wr_data[SUB2_W-1:0]),
		.count    (sub2_count),
		.ovf      (ovf[`RTC_IDX_SUB2])
	);

	rtc_stage #(
		.W (SUB3_W)
	) u_sub3 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (ovf[`RTC_IDX_SUB2]),
		.reload   (sub3_reload),
		.wr_en    (rtc_count_high_wr),
		.wr_data  (rtc_count_high_wr_data[SUB3_W+SUB2_W-1:SUB2_W]),
		.count    (sub3_count),
		.ovf      (ovf[`RTC_IDX_SUB3])
	);

	// ---------------------------------------------------------------------------
	// software view of the 32-bit block
	// ---------------------------------------------------------------------------
	assign rtc_count_high = {sub3_count, sub2_count};
	assign rtc_count_low  = {sub1_count, sub0_count};

	// ---------------------------------------------------------------------------
	// next state: dividers, requests, wake-up
	// ---------------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// main divider runs whenever the main oscillator ticks and the chain runs
		if (run && main_osc_tick) begin
			s_d.main_div = s_q.main_div + `RTC_MAIN_DIV_W'(1);
		end
		// prescaler advances only while enabled, so enabling starts a full 8 count
		if (!prescale_en) begin
			s_d.pre = `RTC_PRE_RST;
		end else if (src_tick) begin
			s_d.pre = s_q.pre + `RTC_PRE_W'(1);
		end
		s_d.req  = ovf & req_en;
		s_d.node = |(ovf & req_en);
		s_d.wake = low_power && (|(ovf & wake_en));
	end

	// power-on reset only; system resets leave the timekeeping intact
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q.main_div <= `RTC_MAIN_DIV_RST;
			s_q.pre      <= `RTC_PRE_RST;
			s_q.req      <= `RTC_REQ_RST;
			s_q.node     <= 1'b0;
			s_q.wake     <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------------------
	assign stage_req = s_q.req;
	assign node_req  = s_q.node;
	assign wakeup    = s_q.wake;

endmodule

/* rtc_divider_chain_properties.sv */
`timescale 1ns/10ps

// -------------------------------------------
// port-level checks of the divider chain
// -------------------------------------------
module rtc_chain_checker #(
	parameter int PRE_TMR_W = 16
) (
	input wire logic                 core_clk,
	input wire logic                 rst_n,
	input wire logic                 low_power,
	input wire logic                 run_in_sleep,
	input wire logic [PRE_TMR_W-1:0] prescaler_timer_reload,
	input wire logic                 prescaler_timer_wr,
	input wire logic [PRE_TMR_W-1:0] prescaler_timer_wr_data,
	input wire logic                 rtc_count_high_wr,
	input wire logic                 rtc_count_low_wr,
	input wire logic [15:0]          rtc_count_high_wr_data,
	input wire logic [15:0]          rtc_count_low_wr_data,
	input wire logic [4:0]           req_en,
	input wire logic [4:0]           wake_en,
	input wire logic [PRE_TMR_W-1:0] prescaler_timer,
	input wire logic [15:0]          rtc_count_high,
	input wire logic [15:0]          rtc_count_low,
	input wire logic [4:0]           stage_req,
	input wire logic                 node_req,
	input wire logic                 wakeup
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// request and wake outputs tied to their causes
	a_node_or_merge: assert property (node_req == |stage_req)
		else $error("node request differs from merged stage requests");
	a_req_needs_en: assert property ((stage_req & ~$past(req_en)) == 5'h00)
		else $error("stage request without enable");
	a_wake_in_sleep: assert property (wakeup |-> $past(low_power) && $past(wake_en) != 5'h00)
		else $error("wakeup outside sleep or without enable");
	// frozen chain while asleep without run permission
	a_sleep_frozen: assert property (low_power && !run_in_sleep && !prescaler_timer_wr
		&& !rtc_count_high_wr && !rtc_count_low_wr |=> stage_req == 5'h00
		&& $stable({prescaler_timer, rtc_count_high, rtc_count_low}))
		else $error("chain moved while frozen");
	// software writes land one cycle later
	a_pre_write: assert property (prescaler_timer_wr |=> prescaler_timer == $past(prescaler_timer_wr_data))
		else $error("prescaler timer write lost");
	a_high_write: assert property (rtc_count_high_wr |=> rtc_count_high == $past(rtc_count_high_wr_data))
		else $error("high count write lost");
	a_low_write: assert property (rtc_count_low_wr |=> rtc_count_low == $past(rtc_count_low_wr_data))
		else $error("low count write lost");
	// counting up, reload on overflow with request
	a_count_up: assert property (prescaler_timer != $past(prescaler_timer) && !(&($past(prescaler_timer)))
		&& !$past(prescaler_timer_wr) |-> prescaler_timer == $past(prescaler_timer) + 1'b1)
		else $error("prescaler timer did not step by one");
	a_ovf_reload: assert property (&($past(prescaler_timer)) && prescaler_timer != $past(prescaler_timer)
		&& !$past(prescaler_timer_wr) |-> prescaler_timer == $past(prescaler_timer_reload)
		&& stage_req[0] == $past(req_en[0]))
		else $error("overflow did not reload or request");
endmodule

bind rtc_divider_chain rtc_chain_checker #(.PRE_TMR_W(PRE_TMR_W)) rtc_chain_checker_inst (.*);

/* tb_rtc_divider_chain.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("mismatch %s exp %h got %h", n, e, a); end end

module tb_rtc_divider_chain;
	logic        core_clk = 1'b0, rst_n = 1'b0, aux_osc_tick = 1'b0, main_osc_tick = 1'b0;
	logic        clk_src_sel = 1'b0, prescale_en = 1'b0, low_power = 1'b0, run_in_sleep = 1'b0;
	logic        prescaler_timer_wr = 1'b0, rtc_count_high_wr = 1'b0, rtc_count_low_wr = 1'b0;
	logic [15:0] prescaler_timer_reload = 16'h0000, prescaler_timer_wr_data = 16'h0000;
	logic [15:0] rtc_count_high_wr_data = 16'h0000, rtc_count_low_wr_data = 16'h0000;
	logic [9:0]  sub0_reload = 10'h000, sub3_reload = 10'h000;
	logic [5:0]  sub1_reload = 6'h00, sub2_reload = 6'h00;
	logic [4:0]  req_en = 5'h00, wake_en = 5'h00, stage_req;
	logic [15:0] prescaler_timer, rtc_count_high, rtc_count_low;
	logic        node_req, wakeup;
	int          fail_count = 0, cmp_count = 0;

	// 200 MHz core clock
	always #2.5 core_clk = ~core_clk;

	rtc_divider_chain rtc_divider_chain_inst (.*);

	// hold a tick source high for n cycles, returns where results show
	task automatic ticks(input int n, input logic main);
		@(negedge core_clk);
		aux_osc_tick = !main;
		main_osc_tick = main;
		repeat (n) @(negedge core_clk);
		aux_osc_tick = 1'b0;
		main_osc_tick = 1'b0;
	endtask

	// load all three count registers in one cycle
	task automatic wr_all(input logic [15:0] pt, input logic [15:0] hi, input logic [15:0] lo);
		@(negedge core_clk);
		{prescaler_timer_wr, rtc_count_high_wr, rtc_count_low_wr} = 3'h7;
		{prescaler_timer_wr_data, rtc_count_high_wr_data, rtc_count_low_wr_data} = {pt, hi, lo};
		@(negedge core_clk);
		{prescaler_timer_wr, rtc_count_high_wr, rtc_count_low_wr} = 3'h0;
	endtask

	task automatic t_walk();
		req_en = 5'h01;
		wake_en = 5'h1f;
		wr_all(16'hffff, 16'h0000, 16'h0000);
		ticks(1, 1'b0);
		`CHK("pt", 16'h0000, prescaler_timer)
		`CHK("low", 16'h0001, rtc_count_low)
		`CHK("req", 5'h01, stage_req)
		`CHK("node", 1'b1, node_req)
		`CHK("wake", 1'b0, wakeup)
		@(negedge core_clk);
		`CHK("req end", 5'h00, stage_req)
		$display("test walk done");
	endtask

	task automatic t_prescale();
		prescale_en = 1'b1;
		wr_all(16'h0000, 16'h0000, 16'h0000);
		ticks(7, 1'b0);
		`CHK("pt 7", 16'h0000, prescaler_timer)
		ticks(1, 1'b0);
		`CHK("pt 8", 16'h0001, prescaler_timer)
		prescale_en = 1'b0;
		$display("test prescale done");
	endtask

	task automatic t_main();
		clk_src_sel = 1'b1;
		wr_all(16'h0000, 16'h0000, 16'h0000);
		ticks(31, 1'b1);
		ticks(1, 1'b0);
		`CHK("pt 31", 16'h0000, prescaler_timer)
		ticks(1, 1'b1);
		`CHK("pt 32", 16'h0001, prescaler_timer)
		clk_src_sel = 1'b0;
		$display("test main done");
	endtask

	task automatic t_carry();
		{sub0_reload, sub1_reload, sub2_reload, sub3_reload} = {10'h002, 6'h01, 6'h03, 10'h3ff};
		{req_en, wake_en, low_power, run_in_sleep} = {5'h1f, 5'h02, 2'h3};
		wr_all(16'hffff, 16'h017f, 16'hffff);
		ticks(1, 1'b0);
		`CHK("low", 16'h0402, rtc_count_low)
		`CHK("high", 16'h0183, rtc_count_high)
		`CHK("req", 5'h0f, stage_req)
		`CHK("node", 1'b1, node_req)
		`CHK("wake", 1'b1, wakeup)
		{wake_en, low_power, run_in_sleep} = 7'h00;
		$display("test carry done");
	endtask

	task automatic t_freeze();
		wr_all(16'hffff, 16'h0000, 16'h0000);
		low_power = 1'b1;
		ticks(3, 1'b0);
		`CHK("pt held", 16'hffff, prescaler_timer)
		`CHK("req held", 5'h00, stage_req)
		low_power = 1'b0;
		ticks(1, 1'b0);
		`CHK("low run", 16'h0001, rtc_count_low)
		$display("test freeze done");
	endtask

	// last sub-timer overflow, non-zero prescaler reload, then a power-on reset mid-run
	task automatic t_top();
		prescaler_timer_reload = 16'h1234;
		wr_all(16'hffff, 16'hffff, 16'hffff);
		ticks(1, 1'b0);
		`CHK("pt rld", 16'h1234, prescaler_timer)
		`CHK("high top", 16'hffc3, rtc_count_high)
		`CHK("low top", 16'h0402, rtc_count_low)
		`CHK("req top", 5'h1f, stage_req)
		`CHK("node top", 1'b1, node_req)
		rst_n = 1'b0;
		@(negedge core_clk);
		rst_n = 1'b1;
		`CHK("pt por", 16'h0000, prescaler_timer)
		`CHK("high por", 16'h0000, rtc_count_high)
		`CHK("low por", 16'h0000, rtc_count_low)
		`CHK("req por", 5'h00, stage_req)
		prescaler_timer_reload = 16'h0000;
		$display("test top done");
	endtask

	// closing verdict, shared by the sequence and the watchdog
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// main sequence after ten reset cycles
	initial begin
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		t_walk();
		t_prescale();
		t_main();
		t_carry();
		t_freeze();
		t_top();
		complete_run();
	end

	// cuts a hang short, tests need well under 1 us
	initial begin
		#20000;
		fail_count++;
		complete_run();
	end
endmodule
